//--- hw/sio_core.sv
/*
 Supervised input classifier, relay override control and front-panel LEDs.
 Resistance readings come from an external converter, already in ohms.
 Switches and buttons are asynchronous and are synchronised here.
*/
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module sio_core import sio_pkg::*; #(
  parameter int FLASH_CYCLES = FLASH_CYC,
  parameter int TX_CYCLES = TX_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NCH*RW-1:0] ohms,
  input wire logic [NOUT*2-1:0] ovr_sw,
  input wire logic poll_strobe,
  input wire logic commission_btn,
  input wire logic reset_btn,
  input wire logic bus_power_ok,
  input wire logic reader_power_ok,
  input wire logic module_fault,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [NOUT-1:0] relay,
  output logic [NOUT-1:0] out_led,
  output logic bus_activity_led,
  output logic manual_led,
  output logic status_led,
  output logic power_led,
  output logic reader_led,
  output logic change_irq,
  output logic commission_req
);
  // Reset button restarts logic; config registers survive it
  logic [2:0] rb_sync_reg;
  wire logic soft_rst = rb_sync_reg[2]; // see RULE24
  wire logic run_n = aresetn & ~soft_rst;

  function automatic logic [15:0] absdiff(input logic [15:0] a,
                                          input logic [15:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction : absdiff

  function automatic input_state_t classify(input logic [15:0] r,
      input logic kind, input logic [15:0] one, input logic [15:0] tol);
    logic [15:0] half;
    half = {1'b0, one[15:1]};
    if (r < SHORT_LIMIT || r > OPEN_LIMIT) begin
      classify = ST_VIOL; // see RULE4 see RULE7
    end else if (absdiff(r, half) <= tol) begin
      classify = kind ? ST_OPEN : ST_NORMAL; // see RULE2 see RULE6
    end else if (absdiff(r, one) <= tol) begin
      classify = kind ? ST_NORMAL : ST_OPEN; // see RULE3 see RULE5
    end else begin
      classify = ST_VIOL; // see RULE8
    end
  endfunction : classify

  // Configuration, kept across the reset button
  logic [NCH-1:0] kind_reg;
  logic [NOUT-1:0] cmd_reg, pol_reg, dis_reg;
  logic locate_reg;
  logic [15:0] tol_reg, single_r_reg;

  // Synchronisers
  logic [NOUT*2-1:0] sw_s1_reg, sw_s2_reg;
  logic [3:0] pin_s1_reg, pin_s2_reg;
  logic cb_s1_reg, cb_s2_reg, cb_d_reg, rb_s1_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_s1_reg <= '0;
      sw_s2_reg <= '0;
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      cb_s1_reg <= 1'b0;
      cb_s2_reg <= 1'b0;
      cb_d_reg <= 1'b0;
      rb_s1_reg <= 1'b0;
      rb_sync_reg <= 3'h0;
    end else begin
      sw_s1_reg <= ovr_sw;
      sw_s2_reg <= sw_s1_reg;
      pin_s1_reg <= {bus_power_ok, reader_power_ok, module_fault,
                     poll_strobe};
      pin_s2_reg <= pin_s1_reg;
      cb_s1_reg <= commission_btn;
      cb_s2_reg <= cb_s1_reg;
      cb_d_reg <= cb_s2_reg;
      rb_s1_reg <= reset_btn;
      rb_sync_reg <= {rb_sync_reg[1], rb_sync_reg[0], rb_s1_reg};
    end
  end

  // Input classification, one classifier per channel
  input_state_t st_now [NCH];
  logic [2*NCH-1:0] st_flat, st_reg;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign st_now[g] = classify(ohms[g*RW +: RW], kind_reg[g],
                                  single_r_reg, tol_reg); // see RULE1
      assign st_flat[2*g +: 2] = st_now[g];
    end
  endgenerate

  // Event reporting only on change
  wire logic changed = (st_flat != st_reg); // see RULE16
  logic poll_d_reg;
  wire logic poll_rise = pin_s2_reg[0] & ~poll_d_reg;
  logic [NCH-1:0] ev_reg;
  // Software clear strobes, decoded with the bus logic below
  logic [NCH-1:0] ev_clr;
  logic [31:0] tx_cnt_reg, fl_cnt_reg;
  logic flash_reg, poll_flash_reg;

  // Relay drive: override wins, disable beats everything
  logic [NOUT-1:0] relay_next, manual_any;
  always_comb begin
    relay_next = '0;
    manual_any = '0;
    for (int i = 0; i < NOUT; i++) begin
      manual_any[i] = (sw_s2_reg[2*i +: 2] != OVR_AUTO); // see RULE18
      if (dis_reg[i]) begin
        relay_next[i] = 1'b0; // see RULE14
      end else if (sw_s2_reg[2*i +: 2] == OVR_ON) begin
        relay_next[i] = 1'b1; // see RULE11
      end else if (sw_s2_reg[2*i +: 2] == OVR_OFF) begin
        relay_next[i] = 1'b0; // see RULE12
      end else begin
        relay_next[i] = cmd_reg[i] ^ pol_reg[i]; // see RULE9 see RULE10 see RULE13
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!run_n) begin
      st_reg <= {NCH{ST_NORMAL}};
      ev_reg <= '0;
      poll_d_reg <= 1'b0;
      tx_cnt_reg <= 32'h0;
      fl_cnt_reg <= 32'h0;
      flash_reg <= 1'b0;
      poll_flash_reg <= 1'b0;
      relay <= '0;
      out_led <= '0;
      bus_activity_led <= 1'b0;
      manual_led <= 1'b0;
      status_led <= 1'b0;
      power_led <= 1'b0;
      reader_led <= 1'b0;
      change_irq <= 1'b0;
      commission_req <= 1'b0;
    end else begin
      st_reg <= st_flat;
      poll_d_reg <= pin_s2_reg[0];
      for (int i = 0; i < NCH; i++) begin
        if (st_flat[2*i +: 2] != st_reg[2*i +: 2]) begin
          ev_reg[i] <= 1'b1; // Set wins over software clear
        end else if (ev_clr[i]) begin
          ev_reg[i] <= 1'b0;
        end
      end
      change_irq <= changed; // see RULE16
      if (changed) begin
        tx_cnt_reg <= TX_CYCLES; // see RULE17
      end else if (tx_cnt_reg != 32'h0) begin
        tx_cnt_reg <= tx_cnt_reg - 32'h1;
      end
      if (fl_cnt_reg >= FLASH_CYCLES - 1) begin
        fl_cnt_reg <= 32'h0;
        flash_reg <= ~flash_reg;
      end else begin
        fl_cnt_reg <= fl_cnt_reg + 32'h1;
      end
      if (poll_rise) begin
        poll_flash_reg <= 1'b1;
      end else if (fl_cnt_reg == 32'h0 && flash_reg) begin
        poll_flash_reg <= 1'b0;
      end
      bus_activity_led <= (tx_cnt_reg != 32'h0) | changed
                          | poll_flash_reg; // see RULE17
      relay <= relay_next;
      out_led <= relay_next; // see RULE21
      manual_led <= |manual_any; // see RULE18
      status_led <= locate_reg | (pin_s2_reg[1] & flash_reg); // see RULE19 see RULE20
      power_led <= pin_s2_reg[3]; // see RULE22
      reader_led <= pin_s2_reg[2]; // see RULE22
      commission_req <= cb_s2_reg & ~cb_d_reg; // see RULE23
    end
  end

  // AXI4-Lite slave; one write and one read in flight
  logic aw_ok_reg, w_ok_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  wire logic do_write = aw_ok_reg & w_ok_reg & ~bvalid;
  assign ev_clr = (do_write && aw_addr_reg == ADDR_EVENT &&
                   w_strb_reg[0]) ? w_data_reg[NCH-1:0] : '0;
  wire logic hit_w = (aw_addr_reg == ADDR_INPUT_CFG) ||
                     (aw_addr_reg == ADDR_OUT_CTRL) ||
                     (aw_addr_reg == ADDR_EVENT) ||
                     (aw_addr_reg == ADDR_LED_CTRL) ||
                     (aw_addr_reg == ADDR_TOL) ||
                     (aw_addr_reg == ADDR_SINGLE_R);
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (araddr)
      ADDR_INPUT_CFG: rd_mux = {29'h0, kind_reg};
      ADDR_INPUT_STAT: rd_mux = {26'h0, st_reg};
      ADDR_OUT_CTRL: rd_mux = {26'h0, dis_reg, pol_reg, cmd_reg};
      ADDR_OUT_STAT: rd_mux = {26'h0, relay, sw_s2_reg}; // see RULE15
      ADDR_EVENT: rd_mux = {29'h0, ev_reg};
      ADDR_LED_CTRL: rd_mux = {31'h0, locate_reg};
      ADDR_TOL: rd_mux = {16'h0, tol_reg};
      ADDR_SINGLE_R: rd_mux = {16'h0, single_r_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kind_reg <= '0;
      cmd_reg <= '0;
      pol_reg <= '0;
      dis_reg <= '0;
      locate_reg <= 1'b0;
      tol_reg <= TOL_RESET;
      single_r_reg <= SINGLE_R_RESET;
    end else if (do_write && w_strb_reg[0]) begin
      case (aw_addr_reg)
        ADDR_INPUT_CFG: kind_reg <= w_data_reg[NCH-1:0];
        ADDR_OUT_CTRL: begin
          cmd_reg <= w_data_reg[1:0];
          pol_reg <= w_data_reg[3:2];
          dis_reg <= w_data_reg[5:4];
        end
        ADDR_LED_CTRL: locate_reg <= w_data_reg[0];
        ADDR_TOL: tol_reg <= w_data_reg[15:0];
        ADDR_SINGLE_R: single_r_reg <= w_data_reg[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_reg <= 1'b0;
      w_ok_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else begin
      awready <= ~aw_ok_reg & ~awready & awvalid;
      wready <= ~w_ok_reg & ~wready & wvalid;
      if (awvalid && awready) begin
        aw_ok_reg <= 1'b1;
        aw_addr_reg <= {awaddr[7:2], 2'h0};
      end
      if (wvalid && wready) begin
        w_ok_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= hit_w ? 2'h0 : 2'h2;
        aw_ok_reg <= 1'b0;
        w_ok_reg <= 1'b0;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      arready <= ~arready & ~rvalid & arvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_hit ? 2'h0 : 2'h2;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  AST_DISABLE_OFF: assert property (@(posedge aclk) disable iff (!run_n)
    dis_reg[0] |=> !relay[0]) // see RULE14
    else $error("Disabled relay energized");
  AST_OVR_ON: assert property (@(posedge aclk) disable iff (!run_n)
    (sw_s2_reg[1:0] == OVR_ON && !dis_reg[0]) |=> relay[0]) // see RULE11
    else $error("Override ON ignored");
  AST_OVR_OFF: assert property (@(posedge aclk) disable iff (!run_n)
    (sw_s2_reg[3:2] == OVR_OFF) |=> !relay[1]) // see RULE12
    else $error("Override OFF ignored");
  AST_AUTO: assert property (@(posedge aclk) disable iff (!run_n)
    (sw_s2_reg[1:0] == OVR_AUTO && !dis_reg[0])
      |=> relay[0] == ($past(cmd_reg[0]) ^ $past(pol_reg[0]))) // see RULE13
    else $error("Auto relay not from command");
  AST_LED_FOLLOW: assert property (@(posedge aclk) disable iff (!run_n)
    out_led == relay) // see RULE21
    else $error("Output LED mismatch");
  AST_MANUAL: assert property (@(posedge aclk) disable iff (!run_n)
    (sw_s2_reg != '0) |=> manual_led) // see RULE18
    else $error("Manual LED not lit");
  AST_CHANGE: assert property (@(posedge aclk) disable iff (!run_n)
    change_irq |-> $past(st_flat) != $past(st_reg)) // see RULE16
    else $error("Report without change");
  AST_LOCATE: assert property (@(posedge aclk) disable iff (!run_n)
    locate_reg |=> status_led) // see RULE20
    else $error("Locate LED off");
  AST_ACT: assert property (@(posedge aclk) disable iff (!run_n)
    changed |=> bus_activity_led [*2]) // see RULE17
    else $error("Activity LED not lit");
endmodule : sio_core

//--- shared/sio_pkg.sv
/*
 Constants for the supervised input and relay override block.
 Assumes a 125 MHz system clock and an AXI4-Lite master for software.
*/
// Functional notes
// RULE1: Three supervised inputs, classified independently
// RULE2: Closed type, half value reads contact closed
// RULE3: Closed type, full value reads contact open
// RULE4: Closed type, short or open is violation
// RULE5: Open type, full value reads closed
// RULE6: Open type, half value reads open
// RULE7: Open type, short or cut is violation
// RULE8: Tolerance bands; between bands is violation
// RULE9: Two relays; ON command energizes relay
// RULE10: Polarity bit inverts command to relay
// RULE11: Override ON forces relay energized
// RULE12: Override OFF forces relay de-energized
// RULE13: Override auto follows program command
// RULE14: Disabled output keeps relay de-energized
// RULE15: Override position readable by software
// RULE16: Report only on input change, plus polls
// RULE17: Activity LED on transmit, flash on poll
// RULE18: Manual LED when any override not auto
// RULE19: Status LED off, on or fast-flash on fault
// RULE20: Status LED lit on controller command
// RULE21: Output LED lit while relay energized
// RULE22: Power and reader-supply LEDs follow supplies
// RULE23: Commission button registers module address
// RULE24: Reset button restarts, keeps configuration
package sio_pkg;
  localparam int NCH = 3;
  localparam int NOUT = 2;
  localparam int RW = 16;
  localparam logic [7:0] ADDR_INPUT_CFG = 8'h00;
  localparam logic [7:0] ADDR_INPUT_STAT = 8'h04;
  localparam logic [7:0] ADDR_OUT_CTRL = 8'h08;
  localparam logic [7:0] ADDR_OUT_STAT = 8'h0C;
  localparam logic [7:0] ADDR_EVENT = 8'h10;
  localparam logic [7:0] ADDR_LED_CTRL = 8'h14;
  localparam logic [7:0] ADDR_TOL = 8'h18;
  localparam logic [7:0] ADDR_SINGLE_R = 8'h1C;
  localparam logic [15:0] SINGLE_R_RESET = 16'h2710;
  localparam logic [15:0] TOL_RESET = 16'h01F4;
  localparam logic [15:0] SHORT_LIMIT = 16'h0064;
  localparam logic [15:0] OPEN_LIMIT = 16'hFFF0;
  localparam int FLASH_NS = 50000000;
  localparam int CLK_NS = 8;
  localparam int FLASH_CYC = FLASH_NS / CLK_NS;
  localparam int TX_NS = 20000000;
  localparam int TX_CYC = TX_NS / CLK_NS;
  localparam logic [1:0] OVR_AUTO = 2'h0;
  localparam logic [1:0] OVR_ON = 2'h1;
  localparam logic [1:0] OVR_OFF = 2'h2;
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_OPEN = 2'b01,
    ST_VIOL = 2'b10
  } input_state_t;
endpackage : sio_pkg

//--- test/ctrl_model.sv
/*
 Controller side model: AXI4-Lite master tasks and the periodic bus check.
 Assumes a slave with registered ready and response signals.
*/
`timescale 1ns/1ps
module ctrl_model (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  output logic poll_strobe,
  output logic hang
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, poll_strobe, hang} = '0;
  end
  // Locate and other commands go out as register writes
  task automatic wr(input logic [7:0] a, input logic [31:0] dv,
      input logic [3:0] s, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dv;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    r = bresp;
    bready <= 1'b0;
    if (n >= 100) hang <= 1'b1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] dv,
      output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    dv = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100) hang <= 1'b1;
  endtask : rd
  // Bus check: a short level pulse
  task automatic poll();
    @(posedge aclk);
    poll_strobe <= 1'b1;
    repeat (3) @(posedge aclk);
    poll_strobe <= 1'b0;
  endtask : poll
endmodule : ctrl_model

//--- test/testbench.sv
/*
 Self-checking bench for sio_core: reset and bus refusal cases, then a table of
 input and relay cases, then event, LED and button cases by hand.
 Assumes ctrl_model drives the register bus and the bus checks.
*/
`timescale 1ns/1ps
module testbench import sio_pkg::*;;
  logic aclk, aresetn, poll_strobe, commission_btn, reset_btn, hang;
  logic bus_power_ok, reader_power_ok, module_fault;
  logic [NCH*RW-1:0] ohms;
  logic [NOUT*2-1:0] ovr_sw;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, hits;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, rs;
  logic [NOUT-1:0] relay, out_led;
  logic bus_activity_led, manual_led, status_led, power_led, reader_led;
  logic change_irq, commission_req;
  wire [3:0] mon = {status_led, commission_req, bus_activity_led, change_irq};
  int err_total, total_checks;
  typedef struct packed {
    logic [2:0] k; logic [15:0] r; logic [1:0] st;
    logic [3:0] sw; logic [5:0] ctl; logic [1:0] rl; logic man;
  } row_t;
  // Kind, ohms, state, switches, control, relays, manual LED
  row_t rows [9] = '{
    '{3'h0, 16'h1388, 2'h0, 4'h0, 6'h01, 2'h1, 1'b0},
    '{3'h0, 16'h2710, 2'h1, 4'h0, 6'h05, 2'h0, 1'b0},
    '{3'h0, 16'h0000, 2'h2, 4'h1, 6'h00, 2'h1, 1'b1},
    '{3'h0, 16'hFFFF, 2'h2, 4'h8, 6'h02, 2'h0, 1'b1},
    '{3'h0, 16'h1D4C, 2'h2, 4'h0, 6'h13, 2'h2, 1'b0},
    '{3'h7, 16'h2710, 2'h0, 4'h4, 6'h00, 2'h2, 1'b1},
    '{3'h7, 16'h1388, 2'h1, 4'h0, 6'h0C, 2'h3, 1'b0},
    '{3'h7, 16'h0032, 2'h2, 4'h3, 6'h01, 2'h1, 1'b1},
    '{3'h7, 16'hFFFF, 2'h2, 4'h0, 6'h00, 2'h0, 1'b0}};
  // Short counts keep flash and transmit windows inside the run
  sio_core #(.FLASH_CYCLES(4), .TX_CYCLES(8)) uut (.*);
  ctrl_model m (.*);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // Pulses are short, so collect every bit seen high in the window
  task automatic seek(input int n);
    hits = 4'h0;
    repeat (n) begin
      @(posedge aclk);
      #1;
      hits = hits | mon;
    end
  endtask : seek
  always @(posedge hang) begin
    err_total++;
    wrap_up();
  end
  initial begin
    err_total = 0;
    total_checks = 0;
    aresetn = 1'b0;
    ohms = {3{16'h1388}};
    ovr_sw = 4'h0;
    {commission_btn, reset_btn, module_fault} = 3'h0;
    {bus_power_ok, reader_power_ok} = 2'h3;
    repeat (12) @(posedge aclk);
    #1;
    chk(relay, 2'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
    m.rd(ADDR_TOL, d, rs);
    chk(d, 32'h1F4);
    m.rd(ADDR_SINGLE_R, d, rs);
    chk(d, 32'h2710);
    m.rd(8'h20, d, rs);
    chk({rs, d}, {2'h2, 32'h0});
    m.wr(8'h24, 32'h1, 4'hF, rs);
    chk(rs, 2'h2);
    m.wr(ADDR_OUT_CTRL, 32'h3, 4'h0, rs);
    m.rd(ADDR_OUT_CTRL, d, rs);
    chk(d, 32'h0);
    foreach (rows[i]) begin
      @(posedge aclk);
      ovr_sw <= rows[i].sw;
      ohms <= {3{rows[i].r}};
      m.wr(ADDR_INPUT_CFG, {29'h0, rows[i].k}, 4'hF, rs);
      m.wr(ADDR_OUT_CTRL, {26'h0, rows[i].ctl}, 4'hF, rs);
      repeat (8) @(posedge aclk);
      #1;
      chk(relay, rows[i].rl);
      chk(out_led, rows[i].rl);
      chk(manual_led, rows[i].man);
      m.rd(ADDR_INPUT_STAT, d, rs);
      chk(d[5:0], {3{rows[i].st}});
      m.rd(ADDR_OUT_STAT, d, rs);
      chk(d[5:0], {rows[i].rl, rows[i].sw});
    end
    m.wr(ADDR_INPUT_CFG, 32'h0, 4'hF, rs);
    @(posedge aclk);
    ohms <= {16'h0000, 16'h2710, 16'h1388};
    repeat (12) @(posedge aclk);
    m.rd(ADDR_INPUT_STAT, d, rs);
    chk(d[5:0], 6'h24);
    m.wr(ADDR_EVENT, 32'hFF, 4'hF, rs);
    m.rd(ADDR_EVENT, d, rs);
    chk(d[2:0], 3'h0);
    seek(20);
    chk(hits[1:0], 2'h0);
    @(posedge aclk);
    ohms[31:16] <= 16'h1388;
    seek(10);
    chk(hits[1:0], 2'h3);
    m.rd(ADDR_EVENT, d, rs);
    chk(d[2:0], 3'h2);
    repeat (20) @(posedge aclk);
    m.poll();
    seek(10);
    chk(hits[1:0], 2'h2);
    m.wr(ADDR_LED_CTRL, 32'h1, 4'hF, rs);
    repeat (3) @(posedge aclk);
    #1;
    chk(status_led, 1'b1);
    m.wr(ADDR_LED_CTRL, 32'h0, 4'hF, rs);
    repeat (3) @(posedge aclk);
    #1;
    chk(status_led, 1'b0);
    @(posedge aclk);
    module_fault <= 1'b1;
    commission_btn <= 1'b1;
    bus_power_ok <= 1'b0;
    seek(20);
    chk(hits[3:2], 2'h3);
    chk({power_led, reader_led}, 2'h1);
    @(posedge aclk);
    {module_fault, commission_btn, bus_power_ok, reader_power_ok} <= 4'h2;
    repeat (6) @(posedge aclk);
    #1;
    chk({power_led, reader_led}, 2'h2);
    m.wr(ADDR_TOL, 32'h258, 4'hF, rs);
    @(posedge aclk);
    reset_btn <= 1'b1;
    repeat (6) @(posedge aclk);
    reset_btn <= 1'b0;
    repeat (10) @(posedge aclk);
    m.rd(ADDR_TOL, d, rs);
    chk(d, 32'h258);
    m.rd(ADDR_EVENT, d, rs);
    chk(d[2:0], 3'h4);
    wrap_up();
  end
endmodule : testbench
